//--- pkg/occ_map.svh
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
// Register indices on the plain register port
`define OCC_ADDR_W        4
`define OCC_REG_CTRL      4'h0
`define OCC_REG_PRI       4'h1
`define OCC_REG_SEC       4'h2
`define OCC_REG_STAT      4'h3
`define OCC_REG_IEN       4'h4
`define OCC_REG_ICLR      4'h5
// Control register fields
`define OCC_CTRL_MODE_HI  2
`define OCC_CTRL_MODE_LO  0
`define OCC_CTRL_TSEL     3
`define OCC_CTRL_FLT      4
`define OCC_CTRL_IDLE     13
`define OCC_CTRL_RESET    16'h0000
`define OCC_CTRL_WMASK    16'h200f
// Event status bits
`define OCC_EV_W          3
`define OCC_EV_PIN        0
`define OCC_EV_FAULT      1
`define OCC_EV_WRAP       2
`define OCC_VAL_RESET     16'h0000
`endif

//--- pkg/occ_pkg.sv
package occ_pkg;
  typedef enum logic [2:0] {
    OCC_OFF, OCC_ONE_HI, OCC_ONE_LO, OCC_TOGGLE,
    OCC_DELAY_ONE, OCC_CONT, OCC_PWM, OCC_PWM_FLT
  } occ_mode_t;
endpackage

//--- pkg/occ_tb_if.sv
`timescale 1ns/1ns
`default_nettype none
// Selected time base shared between the selector and the core
interface occ_tb_if;
  logic [15:0] count;
  logic        wrap;
  logic        run;
  modport src (output count, output wrap, output run);
  modport dst (input count, input wrap, input run);
endinterface
`default_nettype wire

//--- verilog/occ_sync3.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage pin synchroniser; a change is accepted when stages two and three agree
module occ_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output var  logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      o_level <= 1'b1;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/occ_tb_sel.sv
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
// Picks one of the two time bases and flags its period rollover
module occ_tb_sel (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  input  wire logic  i_sel_b,
  input  wire logic  i_idle_halt,
  input  wire logic [15:0] i_tb_a,
  input  wire logic [15:0] i_tb_b,
  occ_tb_if.src      tb
);
  logic [15:0] prev_q;
  logic [15:0] cur;
  assign cur      = i_sel_b ? i_tb_b : i_tb_a;
  assign tb.count = cur;
  assign tb.run   = ~i_idle_halt;
  // Timer going backwards means it reset at its period
  assign tb.wrap  = (cur < prev_q);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_q <= `OCC_VAL_RESET;
    end else begin
      prev_q <= cur;
    end
  end
endmodule
`default_nettype wire

//--- verilog/occ_channel.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module occ_channel
  import occ_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // Register port
  input  wire logic [`OCC_ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output var  logic [15:0]             o_rdata,
  // Time bases and system state
  input  wire logic [15:0]             i_tb_a,
  input  wire logic [15:0]             i_tb_b,
  input  wire logic                    i_cpu_idle,
  input  wire logic                    i_shared_fault_input,
  input  wire logic                    i_gpio_out,
  // Pin and interrupt
  output var  logic                    o_compare_output_pin,
  output var  logic                    o_pin_owned,
  output var  logic                    o_irq
);
  import occ_pkg::*;

  occ_tb_if tb ();

  logic [15:0]            ctrl_q;
  logic [15:0]            pri_q;
  logic [15:0]            sec_q;
  logic [15:0]            duty_q;
  logic                   flt_q;
  logic                   pin_q;
  logic                   pin_d;
  logic                   done_q;
  logic                   flt_prev_q;
  logic [`OCC_EV_W-1:0]   stat_q;
  logic [`OCC_EV_W-1:0]   ien_q;
  logic                   fault_lvl;

  occ_mode_t   mode;
  logic        wr_ctrl;
  logic        wr_pri;
  logic        wr_sec;
  logic        wr_ien;
  logic        wr_iclr;
  logic        run;
  logic        m_pri;
  logic        m_sec;
  logic        rise;
  logic        fall;
  logic        flt_fall;
  logic        ev_pin;
  logic        ev_flt;
  logic [`OCC_EV_W-1:0] ev;
  logic [15:0] ctrl_rd;
  logic [15:0] rd_mux;
  logic        init_pin;
  occ_mode_t   new_mode;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  assign mode     = occ_mode_t'(ctrl_q[`OCC_CTRL_MODE_HI:`OCC_CTRL_MODE_LO]);
  assign new_mode = occ_mode_t'(i_wdata[`OCC_CTRL_MODE_HI:`OCC_CTRL_MODE_LO]);
  assign wr_ctrl  = i_wr && (i_addr == `OCC_REG_CTRL);
  assign wr_pri   = i_wr && (i_addr == `OCC_REG_PRI);
  assign wr_sec   = i_wr && (i_addr == `OCC_REG_SEC);
  assign wr_ien   = i_wr && (i_addr == `OCC_REG_IEN);
  assign wr_iclr  = i_wr && (i_addr == `OCC_REG_ICLR);

  occ_sync3 u_flt (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_shared_fault_input),
    .o_level (fault_lvl)
  );

  occ_tb_sel u_tb (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_sel_b     (ctrl_q[`OCC_CTRL_TSEL]),
    .i_idle_halt (i_cpu_idle && ctrl_q[`OCC_CTRL_IDLE]),
    .i_tb_a      (i_tb_a),
    .i_tb_b      (i_tb_b),
    .tb          (tb)
  );

  assign run      = tb.run;
  assign m_pri    = run && hit(tb.count, pri_q);
  assign m_sec    = run && hit(tb.count, sec_q);
  assign flt_fall = flt_prev_q && !fault_lvl;
  assign init_pin = (pri_q != `OCC_VAL_RESET);

  // Next pin level per mode
  always_comb begin
    pin_d = pin_q;
    case (mode)
      OCC_OFF: begin
        pin_d = pin_q;
      end
      OCC_ONE_HI: begin
        if (m_pri) begin
          pin_d = 1'b1;
        end
      end
      OCC_ONE_LO: begin
        if (m_pri) begin
          pin_d = 1'b0;
        end
      end
      OCC_TOGGLE: begin
        if (m_pri) begin
          pin_d = ~pin_q;
        end
      end
      OCC_DELAY_ONE: begin
        if (m_pri && !done_q) begin
          pin_d = 1'b1;
        end else if (m_sec && pin_q) begin
          pin_d = 1'b0;
        end
      end
      OCC_CONT: begin
        if (m_pri) begin
          pin_d = 1'b1;
        end else if (m_sec) begin
          pin_d = 1'b0;
        end
      end
      OCC_PWM, OCC_PWM_FLT: begin
        if (mode == OCC_PWM_FLT && (flt_q || !fault_lvl)) begin
          pin_d = 1'b0;
        end else if (run && tb.wrap) begin
          pin_d = (pri_q != `OCC_VAL_RESET);
        end else if (run && hit(tb.count, duty_q)) begin
          pin_d = 1'b0;
        end
      end
      default: begin
        pin_d = pin_q;
      end
    endcase
  end

  assign rise   = pin_d && !pin_q;
  assign fall   = !pin_d && pin_q;
  assign ev_pin = !wr_ctrl && (((mode == OCC_ONE_HI) && rise)
                || ((mode == OCC_ONE_LO) && fall)
                || ((mode == OCC_TOGGLE) && (rise || fall))
                || ((mode == OCC_DELAY_ONE) && fall)
                || ((mode == OCC_CONT) && fall));
  assign ev_flt = (mode == OCC_PWM_FLT) && flt_fall;
  assign ev     = {(run && tb.wrap && (mode == OCC_PWM || mode == OCC_PWM_FLT)),
                   ev_flt, ev_pin};

  assign ctrl_rd = {2'b00, ctrl_q[`OCC_CTRL_IDLE], 8'h00, flt_q,
                    ctrl_q[`OCC_CTRL_TSEL:0]};
  assign rd_mux  = (i_addr == `OCC_REG_CTRL) ? ctrl_rd :
                   (i_addr == `OCC_REG_PRI)  ? pri_q :
                   (i_addr == `OCC_REG_SEC)  ? sec_q :
                   (i_addr == `OCC_REG_STAT) ? {13'h0000, stat_q} :
                   (i_addr == `OCC_REG_IEN)  ? {13'h0000, ien_q} : 16'h0000;

  // Registers and the bus; software is expected to stop the timer first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= `OCC_CTRL_RESET;
      pri_q  <= `OCC_VAL_RESET;
      sec_q  <= `OCC_VAL_RESET;
      ien_q  <= '0;
      stat_q <= '0;
      o_rdata <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_wdata & `OCC_CTRL_WMASK;
      end
      if (wr_pri) begin
        pri_q <= i_wdata;
      end
      if (wr_sec) begin
        sec_q <= i_wdata;
      end
      if (wr_ien) begin
        ien_q <= i_wdata[`OCC_EV_W-1:0];
      end
      // Set wins over clear
      stat_q <= (stat_q & ~(wr_iclr ? i_wdata[`OCC_EV_W-1:0] : '0)) | ev;
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  // Pin, duty shadow, fault latch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_q      <= 1'b0;
      done_q     <= 1'b0;
      duty_q     <= `OCC_VAL_RESET;
      flt_q      <= 1'b0;
      flt_prev_q <= 1'b1;
    end else begin
      flt_prev_q <= fault_lvl;
      if (wr_ctrl) begin
        done_q <= 1'b0;
        flt_q  <= 1'b0;
        duty_q <= pri_q;
        case (new_mode)
          OCC_ONE_HI, OCC_DELAY_ONE, OCC_CONT: pin_q <= 1'b0;
          OCC_ONE_LO: pin_q <= 1'b1;
          OCC_PWM, OCC_PWM_FLT: pin_q <= init_pin;
          default: pin_q <= pin_q;
        endcase
      end else begin
        pin_q <= pin_d;
        if (mode == OCC_DELAY_ONE && fall) begin
          done_q <= 1'b1;
        end
        if (mode == OCC_PWM_FLT && !fault_lvl) begin
          flt_q <= 1'b1;
        end
        if (run && tb.wrap) begin
          duty_q <= pri_q;
        end
      end
    end
  end

  // Output stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_compare_output_pin <= 1'b0;
      o_pin_owned          <= 1'b0;
      o_irq                <= 1'b0;
    end else begin
      o_pin_owned          <= (mode != OCC_OFF);
      o_compare_output_pin <= (mode == OCC_OFF) ? i_gpio_out : pin_q;
      o_irq                <= |(stat_q & ien_q);
    end
  end
endmodule
`default_nettype wire

//--- testbench/occ_load.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side circuit: pulls the shared fault line up, drives it low on command
module occ_load (
  // Command from the bench
  input  wire logic i_fault_cmd,
  // Fault line
  output var  logic o_fault_n
);
  assign o_fault_n = i_fault_cmd ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- testbench/occ_channel_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module occ_channel_chk (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Register port
  input  wire logic [`OCC_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [15:0]            o_rdata,
  // Time bases and pins
  input  wire logic [15:0]            i_tb_a,
  input  wire logic [15:0]            i_tb_b,
  input  wire logic                   i_shared_fault_input,
  input  wire logic                   i_gpio_out,
  input  wire logic                   o_compare_output_pin,
  input  wire logic                   o_pin_owned,
  input  wire logic                   o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [2:0] mode_q;
  wire logic ctrl_wr = i_wr && (i_addr == `OCC_REG_CTRL);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= 3'h0;
    end else if (ctrl_wr) begin
      mode_q <= i_wdata[2:0];
    end
  end
  sequence s_on;
    (mode_q != 3'h0)[*3];
  endsequence
  sequence s_wr_hi;
    ctrl_wr && (i_wdata[2:0] == 3'h2) ##1 (!ctrl_wr && $stable(i_tb_a) && $stable(i_tb_b))[*3];
  endsequence
  property p_rd_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
  property p_ctrl_rsvd;
    i_rd && i_addr == `OCC_REG_CTRL |=> o_rdata[15:14] == 2'h0 && o_rdata[12:5] == 8'h00;
  endproperty
  property p_unmapped; i_rd && i_addr > `OCC_REG_ICLR |=> o_rdata == 16'h0000; endproperty
  property p_owned; s_on |-> o_pin_owned; endproperty
  property p_released; (mode_q == 3'h0)[*3] |-> !o_pin_owned; endproperty
  property p_gpio;
    (mode_q == 3'h0 && $stable(i_gpio_out))[*3] |-> o_compare_output_pin == i_gpio_out;
  endproperty
  property p_init_hi; s_wr_hi |-> o_compare_output_pin; endproperty
  property p_irq_off; i_wr && i_addr == `OCC_REG_IEN && i_wdata == 16'h0000 |-> ##2 !o_irq; endproperty
  property p_fault;
    (mode_q == 3'h7 && !i_shared_fault_input)[*8] |-> !o_compare_output_pin;
  endproperty
  a_rd_idle:   assert property (p_rd_idle) else $error("read data not zero");
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");
  a_unmapped:  assert property (p_unmapped) else $error("unmapped read not zero");
  a_owned:     assert property (p_owned) else $error("pin not owned");
  a_released:  assert property (p_released) else $error("pin not released");
  a_gpio:      assert property (p_gpio) else $error("pin not port value");
  a_init_hi:   assert property (p_init_hi) else $error("pin not high");
  a_irq_off:   assert property (p_irq_off) else $error("irq with no enable");
  a_fault:     assert property (p_fault) else $error("pin not forced low");
endmodule
bind occ_channel occ_channel_chk u_occ_channel_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_tb_a(i_tb_a), .i_tb_b(i_tb_b), .i_shared_fault_input(i_shared_fault_input),
  .i_gpio_out(i_gpio_out), .o_compare_output_pin(o_compare_output_pin),
  .o_pin_owned(o_pin_owned), .o_irq(o_irq));
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module testbench;
  import occ_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, idle, gpio, run, clr, tsel, flt;
  logic [`OCC_ADDR_W-1:0] addr;
  logic [15:0] wdata, cnt;
  wire logic [15:0] rdata, tb_a, tb_b;
  wire logic pin, owned, irq, flt_n;
  int n_fail = 0;
  int n_compared = 0;
  assign tb_a = tsel ? 16'h0000 : cnt;
  assign tb_b = tsel ? cnt : 16'h0000;
  occ_channel u_occ_channel (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_tb_a(tb_a), .i_tb_b(tb_b),
    .i_cpu_idle(idle), .i_shared_fault_input(flt_n), .i_gpio_out(gpio),
    .o_compare_output_pin(pin), .o_pin_owned(owned), .o_irq(irq));
  occ_load u_occ_load (.i_fault_cmd(flt), .o_fault_n(flt_n));
  // Time base with a 64-count period
  always_ff @(posedge i_clk) begin
    if (i_rst || clr) begin
      cnt <= 16'h0000;
    end else if (run) begin
      cnt <= (cnt == 16'h003f) ? 16'h0000 : cnt + 16'h0001;
    end
  end
  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = rdata;
    @(posedge i_clk);
    cmp(v & m, e, "read");
  endtask
  task automatic pchk(input logic e);
    #1 cmp({15'h0, pin}, {15'h0, e}, "pin");
  endtask
  // Waits for a count, lets the pin settle, then checks it
  task automatic at(input logic [15:0] k, input logic e);
    for (int i = 0; i < 200 && cnt !== k; i++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
    pchk(e);
  endtask
  task automatic cfg(input logic [15:0] c, input logic [15:0] p, input logic [15:0] s);
    run <= 1'b0;
    clr <= 1'b1;
    wr(`OCC_REG_PRI, p);
    clr <= 1'b0;
    wr(`OCC_REG_SEC, s);
    wr(`OCC_REG_CTRL, c);
    wr(`OCC_REG_ICLR, 16'h0007);
    run <= 1'b1;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    {i_rst, i_wr, i_rd, idle, gpio, run, clr, tsel, flt} = 9'h100;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdc(`OCC_REG_CTRL, 16'hffff, 16'h0000);
    rdc(`OCC_REG_STAT, 16'hffff, 16'h0000);
    rdc(4'hf, 16'hffff, 16'h0000);
    wr(`OCC_REG_CTRL, 16'hffee);
    rdc(`OCC_REG_CTRL, 16'hffff, 16'h200e);
    wr(`OCC_REG_CTRL, 16'h0000);
    wr(`OCC_REG_IEN, 16'h0000);
    gpio <= 1'b1;
    wr(`OCC_REG_IEN, 16'h0003);
    pchk(1'b1);
    cmp({15'h0, owned}, 16'h0000, "owned");
    cfg(16'h0001, 16'h0014, 16'h0000);
    pchk(1'b0);
    at(16'h0014, 1'b1);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0001);
    cmp({15'h0, irq}, 16'h0001, "irq");
    cfg(16'h0002, 16'h0014, 16'h0000);
    pchk(1'b1);
    cmp({15'h0, irq}, 16'h0000, "irq");
    at(16'h0014, 1'b0);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0001);
    cfg(16'h0003, 16'h0010, 16'h0000);
    pchk(1'b0);
    at(16'h0010, 1'b1);
    wr(`OCC_REG_ICLR, 16'h0003);
    at(16'h0010, 1'b0);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0001);
    cfg(16'h0004, 16'h0010, 16'h0020);
    at(16'h0010, 1'b1);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0000);
    at(16'h0020, 1'b0);
    at(16'h0010, 1'b0);
    cfg(16'h0005, 16'h0010, 16'h0020);
    at(16'h0010, 1'b1);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0000);
    at(16'h0020, 1'b0);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0001);
    at(16'h0010, 1'b1);
    cfg(16'h0006, 16'h0000, 16'h0000);
    pchk(1'b0);
    cfg(16'h0006, 16'h0020, 16'h0000);
    pchk(1'b1);
    at(16'h0020, 1'b0);
    at(16'h0004, 1'b1);
    flt <= 1'b1;
    at(16'h000e, 1'b1);
    flt <= 1'b0;
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0000);
    wr(`OCC_REG_PRI, 16'h0030);
    at(16'h0024, 1'b0);
    at(16'h0024, 1'b1);
    at(16'h0034, 1'b0);
    cfg(16'h0007, 16'h0020, 16'h0000);
    at(16'h0004, 1'b1);
    flt <= 1'b1;
    at(16'h000e, 1'b0);
    rdc(`OCC_REG_CTRL, 16'hffff, 16'h0017);
    rdc(`OCC_REG_STAT, 16'h0003, 16'h0002);
    flt <= 1'b0;
    at(16'h0004, 1'b0);
    cfg(16'h0007, 16'h0020, 16'h0000);
    rdc(`OCC_REG_CTRL, 16'hffff, 16'h0007);
    pchk(1'b1);
    for (int s = 0; s < 2; s++) begin
      tsel <= s[0];
      cfg(16'h0009, 16'h0014, 16'h0000);
      at(16'h0014, s[0]);
    end
    tsel <= 1'b0;
    idle <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      cfg(s[0] ? 16'h0001 : 16'h2001, 16'h0014, 16'h0000);
      at(16'h0014, s[0]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
